// ===== isad_uart.sv
// Purpose: Serial port with 16-word queues and automatic driver direction.
// Assumes: pclk at 250 MHz; line_rxd comes from an unsynchronised pin.
// Notes:   Driver and receiver enables follow the transmit state machine in two-wire mode.
//
// Register access over APB and the register addresses were decided locally.
`timescale 1ns/1ps
`include "isad_regs.svh"
module isad_uart #(
    parameter int FIFO_DEPTH = 16,
    parameter int DIV_W      = 16
) (
    // Clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // APB slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    // Serial line
    output logic                   line_txd,
    output logic                   line_drv_en,
    input  wire logic              line_rxd,
    output logic                   line_rx_en,
    output isad_pkg::isad_line_t   line_mode
);
    import isad_pkg::*;

    // Divisor must fit the 24-bit baud counter
    if (DIV_W < 1 || DIV_W > 16)
    begin : g_chk
        $error("isad_uart: DIV_W must be 1 to 16");
    end

    typedef struct packed {
        logic [8:0]       ctrl;
        logic [DIV_W-1:0] div;
        logic [23:0]      bcnt;
        isad_tx_st_t      tst;
        logic [7:0]       tcnt;
        logic [2:0]       tbit;
        logic [7:0]       tsh;
        logic             tpar;
        isad_rx_st_t      rst;
        logic [3:0]       rcnt;
        logic [2:0]       rbit;
        logic [7:0]       rsh;
        logic             rpar;
        logic             sync1;
        logic             sync2;
        logic             perr;
        logic             ferr;
        logic             oerr;
        logic             txd;
        logic             drv;
        logic             rxen;
        logic [31:0]      prdata;
    } isad_st_t;

    isad_st_t s;
    isad_st_t n;

    // Parity over the configured number of data bits
    function automatic logic par_of(input logic [7:0] d,
                                    input logic [1:0] len);
        logic [7:0] mask;
        mask = 8'hff >> (2'd3 - len);
        return ^(d & mask);
    endfunction

    // Stop interval in oversample ticks
    function automatic logic [7:0] stop_ticks(input logic [1:0] st);
        logic [7:0] t;
        case (st)
            2'b00:   t = `ISAD_OVS;
            2'b01:   t = `ISAD_STOP15;
            default: t = `ISAD_STOP2;
        endcase
        return t;
    endfunction

    // Address decode, used by the error path only
    function automatic logic addr_ok(input logic [7:0] a);
        return a == `ISAD_OFF_DATA || a == `ISAD_OFF_CTRL ||
               a == `ISAD_OFF_DIV  || a == `ISAD_OFF_STAT;
    endfunction

    // Queue handshakes
    logic       tx_in_valid;
    logic       tx_in_ready;
    logic       tx_out_valid;
    logic       tx_out_ready;
    logic [7:0] tx_out_data;
    logic       rx_in_valid;
    logic       rx_in_ready;
    logic [7:0] rx_in_data;
    logic       rx_out_valid;
    logic       rx_out_ready;
    logic [7:0] rx_out_data;

    // Decoded configuration and helpers
    logic [1:0]  len;
    isad_par_t   pmode;
    logic        par_en;
    logic        sel485;
    logic        sel422;
    logic        p2p;
    logic [23:0] lim;
    logic        tick;
    logic [7:0]  char_m1;
    logic [7:0]  stop_m1;
    logic        rxs;
    logic        acc;
    logic        done;
    logic [2:0]  clr;
    logic [2:0]  set;

    always_comb
    begin
        n   = s;
        len = s.ctrl[`ISAD_LEN_LSB +: 2];
        // Unused parity code behaves as none
        pmode  = isad_par_t'(s.ctrl[`ISAD_PAR_LSB +: 2]);
        par_en = (pmode == PAR_EVEN) || (pmode == PAR_ODD);
        sel485 = s.ctrl[`ISAD_SEL485_BIT];
        sel422 = s.ctrl[`ISAD_SEL422_BIT];
        p2p    = sel422 && !sel485;

        // Baud tick: divisor times range prescale, zero treated as one
        lim = 24'(s.div == '0 ? 1 : s.div) *
              (s.ctrl[`ISAD_RANGE_BIT] ? `ISAD_PRE_HIGH : `ISAD_PRE_BASE);
        tick   = (s.bcnt >= lim - 24'd1);
        n.bcnt = tick ? 24'd0 : s.bcnt + 24'd1;

        // One character time in ticks, from the live frame format
        stop_m1 = stop_ticks(s.ctrl[`ISAD_STOP_LSB +: 2]) - 8'd1;
        char_m1 = 8'((8'd6 + {6'd0, len} + {7'd0, par_en}) * `ISAD_OVS)
                  + stop_m1;

        // Transmit sequencer
        tx_out_ready = (s.tst == TX_IDLE) || (s.tst == TX_HOLD);
        case (s.tst)
            TX_IDLE, TX_HOLD:
            begin
                // New data restarts without dropping the driver
                if (tx_out_valid)
                begin
                    n.tst  = TX_START;
                    n.tcnt = `ISAD_OVS - 8'd1;
                    n.tsh  = tx_out_data;
                    n.tpar = par_of(tx_out_data, len) ^ (pmode == PAR_ODD);
                end
                else if (s.tst == TX_HOLD && tick)
                begin
                    if (s.tcnt == 8'd0)
                    begin
                        n.tst = TX_IDLE;
                    end
                    else
                    begin
                        n.tcnt = s.tcnt - 8'd1;
                    end
                end
            end
            TX_START, TX_DATA, TX_PAR, TX_STOP:
            begin
                if (tick && s.tcnt != 8'd0)
                begin
                    n.tcnt = s.tcnt - 8'd1;
                end
                else if (tick)
                begin
                    n.tcnt = `ISAD_OVS - 8'd1;
                    case (s.tst)
                        TX_START:
                        begin
                            n.tst  = TX_DATA;
                            n.tbit = {1'b1, len};
                        end
                        TX_DATA:
                        begin
                            n.tsh  = s.tsh >> 1;
                            n.tbit = s.tbit - 3'd1;
                            if (s.tbit == 3'd0)
                            begin
                                n.tst  = par_en ? TX_PAR : TX_STOP;
                                n.tcnt = par_en ? n.tcnt : stop_m1;
                            end
                        end
                        TX_PAR:
                        begin
                            n.tst  = TX_STOP;
                            n.tcnt = stop_m1;
                        end
                        default:
                        begin
                            n.tst  = TX_HOLD;
                            n.tcnt = char_m1;
                        end
                    endcase
                end
            end
            default:
            begin
                n.tst = TX_IDLE;
            end
        endcase

        // Line outputs follow the next state so they leave flops
        case (n.tst)
            TX_START: n.txd = 1'b0;
            TX_DATA:  n.txd = n.tsh[0];
            TX_PAR:   n.txd = n.tpar;
            default:  n.txd = 1'b1;
        endcase
        n.drv  = p2p || (n.tst != TX_IDLE);
        n.rxen = sel422 || (n.tst == TX_IDLE);

        // Receive sync; blocked receiver reads as idle line
        n.sync1 = line_rxd;
        n.sync2 = s.sync1;
        rxs     = s.sync2 || !s.rxen;
        rx_in_valid = 1'b0;
        rx_in_data  = s.rsh >> (2'd3 - len);
        set         = 3'b000;
        case (s.rst)
            RX_IDLE:
            begin
                if (!rxs)
                begin
                    n.rst  = RX_START;
                    n.rcnt = `ISAD_OVS_HALF - 4'd1;
                end
            end
            RX_START, RX_DATA, RX_PAR, RX_STOP:
            begin
                if (tick && s.rcnt != 4'd0)
                begin
                    n.rcnt = s.rcnt - 4'd1;
                end
                else if (tick)
                begin
                    n.rcnt = 4'hf;
                    case (s.rst)
                        RX_START:
                        begin
                            // False start: line back high mid-bit
                            n.rst  = rxs ? RX_IDLE : RX_DATA;
                            n.rbit = {1'b1, len};
                        end
                        RX_DATA:
                        begin
                            n.rsh  = {rxs, s.rsh[7:1]};
                            n.rbit = s.rbit - 3'd1;
                            if (s.rbit == 3'd0)
                            begin
                                n.rst = par_en ? RX_PAR : RX_STOP;
                            end
                        end
                        RX_PAR:
                        begin
                            n.rpar = rxs;
                            n.rst  = RX_STOP;
                        end
                        default:
                        begin
                            // Only the first stop bit is checked
                            rx_in_valid = 1'b1;
                            set[0] = par_en && ((par_of(rx_in_data, len) ^
                                     s.rpar) != (pmode == PAR_ODD));
                            set[1] = !rxs;
                            set[2] = !rx_in_ready;
                            n.rst  = RX_IDLE;
                        end
                    endcase
                end
            end
            default:
            begin
                n.rst = RX_IDLE;
            end
        endcase

        // APB: stall writes to a full transmit queue
        acc          = psel && penable;
        pready       = !(acc && pwrite && paddr == `ISAD_OFF_DATA &&
                         !tx_in_ready);
        pslverr      = acc && !addr_ok(paddr);
        done         = acc && pready;
        tx_in_valid  = acc && pwrite && paddr == `ISAD_OFF_DATA;
        rx_out_ready = done && !pwrite && paddr == `ISAD_OFF_DATA;
        clr          = (done && pwrite && paddr == `ISAD_OFF_STAT) ?
                       pwdata[`ISAD_ERR_LSB +: 3] : 3'b000;
        if (done && pwrite && paddr == `ISAD_OFF_CTRL)
        begin
            n.ctrl = pwdata[8:0];
        end
        if (done && pwrite && paddr == `ISAD_OFF_DIV)
        begin
            n.div = pwdata[DIV_W-1:0];
        end
        // Set wins over a same-cycle clear
        n.perr = (s.perr && !clr[0]) || set[0];
        n.ferr = (s.ferr && !clr[1]) || set[1];
        n.oerr = (s.oerr && !clr[2]) || set[2];

        // Read data captured in the setup cycle
        if (psel && !penable)
        begin
            case (paddr)
                `ISAD_OFF_DATA: n.prdata = {24'h0,
                                 rx_out_valid ? rx_out_data : 8'h00};
                `ISAD_OFF_CTRL: n.prdata = {23'h0, s.ctrl};
                `ISAD_OFF_DIV:  n.prdata = 32'(s.div);
                `ISAD_OFF_STAT: n.prdata = {23'h0, s.oerr, s.ferr, s.perr,
                                 s.rxen, s.drv, !rx_in_ready, rx_out_valid,
                                 !tx_in_ready, !tx_out_valid};
                default:        n.prdata = 32'h0;
            endcase
        end
    end

    // State register; constants only under reset
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s       <= '0;
            s.ctrl  <= `ISAD_CTRL_RST;
            s.div   <= DIV_W'(`ISAD_DIV_RST);
            s.sync1 <= 1'b1;
            s.sync2 <= 1'b1;
            s.txd   <= 1'b1;
            s.rxen  <= 1'b1;
        end
        else
        begin
            s <= n;
        end
    end

    // Outputs from flops; line_mode is decoded from the ctrl flops
    assign prdata      = s.prdata;
    assign line_txd    = s.txd;
    assign line_drv_en = s.drv;
    assign line_rx_en  = s.rxen;
    assign line_mode   = p2p ? LINE_P2P :
                         (sel422 ? LINE_FOUR_WIRE : LINE_TWO_WIRE);

    // Transmit queue, stalls APB when full
    isad_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_txq (
        .pclk      (pclk),
        .presetn   (presetn),
        .in_valid  (tx_in_valid),
        .in_ready  (tx_in_ready),
        .in_data   (pwdata[7:0]),
        .out_valid (tx_out_valid),
        .out_ready (tx_out_ready),
        .out_data  (tx_out_data)
    );

    // Receive queue, drained by APB reads
    isad_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_rxq (
        .pclk      (pclk),
        .presetn   (presetn),
        .in_valid  (rx_in_valid),
        .in_ready  (rx_in_ready),
        .in_data   (rx_in_data),
        .out_valid (rx_out_valid),
        .out_ready (rx_out_ready),
        .out_data  (rx_out_data)
    );

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    drv_on_pending_a: assert property (
        (s.tst == TX_IDLE && tx_out_valid) |=> (line_drv_en && s.tst == TX_START))
        else $error("driver not raised for pending data");
    hold_entry_a: assert property (
        (s.tst == TX_STOP && tick && s.tcnt == 8'd0)
        |=> (s.tst == TX_HOLD && s.tcnt == $past(char_m1)))
        else $error("hold not one character long");
    hold_end_a: assert property (
        (s.tst == TX_HOLD && !tx_out_valid && tick && s.tcnt == 8'd0 && !p2p)
        |=> (s.tst == TX_IDLE && !line_drv_en))
        else $error("driver not released after hold");
    rx_block_a: assert property (
        (!sel422 && $past(!sel422) && line_drv_en) |-> !line_rx_en)
        else $error("receiver live while driving two-wire");
    rx_reenable_a: assert property (
        ($fell(line_drv_en) && !sel422) |-> line_rx_en)
        else $error("receiver not restored after hold");
    data_bits_a: assert property (
        (s.tst == TX_START && tick && s.tcnt == 8'd0) |=> s.tbit == {1'b1, $past(len)})
        else $error("wrong data bit count");
    parity_out_a: assert property (
        (s.tst == TX_PAR) |-> line_txd == s.tpar)
        else $error("parity bit not on line");
    stop_len_a: assert property (
        (s.tst != TX_STOP ##1 s.tst == TX_STOP) |-> s.tcnt == stop_m1)
        else $error("stop interval wrong");
    tick_rate_a: assert property (
        tick |=> s.bcnt == 24'd0)
        else $error("baud counter not restarted");
    p2p_drive_a: assert property (
        (p2p && $past(p2p)) |-> line_drv_en)
        else $error("point-to-point driver off");

    hold_seen_c:    cover property (s.tst == TX_HOLD ##1 s.tst == TX_IDLE);
    hold_restart_c: cover property (s.tst == TX_HOLD ##1 s.tst == TX_START);
    rx_push_c:      cover property (rx_in_valid && rx_in_ready);
    par_err_c:      cover property (set[0]);

endmodule

// ===== isad_regs.svh
// Purpose: Register offsets, field positions, reset values and timing counts
//          for the auto-direction serial port.
// Assumes: APB with 32-bit data, one aligned word per register.
// Notes:   Definitions only.
//
// Summary of operation
// - Driver turns on when data is pending
// - Driver held one character after last
// - Receiver blocked while sending, plus one character, in two-wire mode
// - Hold length tracks the programmed baud rate
// - Five to eight data bits per character
// - Even, odd or no parity, generated and checked
// - One, one and half, or two stops
// - Base range to 115200, high range four times
// - Sixteen-byte queues both directions
// - Full duplex, or half duplex on shared pair
// - Two-wire, four-wire and point-to-point line modes
`ifndef ISAD_REGS_SVH
`define ISAD_REGS_SVH

// Register byte offsets
`define ISAD_OFF_DATA   8'h00
`define ISAD_OFF_CTRL   8'h04
`define ISAD_OFF_DIV    8'h08
`define ISAD_OFF_STAT   8'h0c

// Control field positions
`define ISAD_LEN_LSB    0
`define ISAD_STOP_LSB   2
`define ISAD_PAR_LSB    4
`define ISAD_RANGE_BIT  6
`define ISAD_SEL485_BIT 7
`define ISAD_SEL422_BIT 8

// Status field positions
`define ISAD_ERR_LSB    6

// Reset values
`define ISAD_CTRL_RST   9'h083
`define ISAD_DIV_RST    16'h0001

// Timing counts in clock cycles and oversample ticks
`define ISAD_PRE_BASE   24'd136
`define ISAD_PRE_HIGH   24'd34
`define ISAD_OVS        8'd16
`define ISAD_OVS_HALF   4'd8
`define ISAD_STOP15     8'd24
`define ISAD_STOP2      8'd32

`endif

// ===== isad_pkg.sv
// Purpose: Types shared by the auto-direction serial port.
// Assumes: Nothing beyond the register header.
// Notes:   Gray codes follow the forward state path, not the return to idle.
package isad_pkg;

    typedef enum logic [2:0] {
        TX_IDLE  = 3'b000,
        TX_START = 3'b001,
        TX_DATA  = 3'b011,
        TX_PAR   = 3'b010,
        TX_STOP  = 3'b110,
        TX_HOLD  = 3'b111
    } isad_tx_st_t;

    typedef enum logic [2:0] {
        RX_IDLE  = 3'b000,
        RX_START = 3'b001,
        RX_DATA  = 3'b011,
        RX_PAR   = 3'b010,
        RX_STOP  = 3'b110
    } isad_rx_st_t;

    typedef enum logic [1:0] {
        PAR_NONE = 2'b00,
        PAR_EVEN = 2'b01,
        PAR_ODD  = 2'b10
    } isad_par_t;

    typedef enum logic [1:0] {
        LINE_TWO_WIRE  = 2'b00,
        LINE_FOUR_WIRE = 2'b01,
        LINE_P2P       = 2'b10
    } isad_line_t;

endpackage

// ===== isad_fifo.sv
// Purpose: Synchronous FIFO with valid/ready on both sides.
// Assumes: DEPTH is a power of two.
// Notes:   Head word is read straight from the storage flops.
`timescale 1ns/1ps
module isad_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input  wire logic             pclk,
    input  wire logic             presetn,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);

    // Depth must be a power of two for pointer wrap
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
    begin : g_chk
        $error("isad_fifo: DEPTH must be a power of two");
    end

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW:0]                 wp;
        logic [AW:0]                 rp;
    } isad_fifo_st_t;

    isad_fifo_st_t q_ff;
    isad_fifo_st_t nxt_q;
    logic [AW:0]   level;

    // Full and empty from extended pointers
    always_comb
    begin
        level     = q_ff.wp - q_ff.rp;
        in_ready  = (level != (AW+1)'(DEPTH));
        out_valid = (level != '0);
        out_data  = q_ff.mem[q_ff.rp[AW-1:0]];
        nxt_q     = q_ff;
        if (in_valid && in_ready)
        begin
            nxt_q.mem[q_ff.wp[AW-1:0]] = in_data;
            nxt_q.wp = q_ff.wp + 1'b1;
        end
        if (out_valid && out_ready)
        begin
            nxt_q.rp = q_ff.rp + 1'b1;
        end
    end

    // State register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            q_ff <= '0;
        end
        else
        begin
            q_ff <= nxt_q;
        end
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    level_bound_a: assert property (level <= (AW+1)'(DEPTH))
        else $error("fifo level above depth");
    full_stall_a: assert property (!in_ready |=> $stable(q_ff.wp))
        else $error("write accepted while full");

endmodule

// ===== isad_node.sv
// Purpose: Remote node on the shared serial pair.
// Assumes: BIT clocks per bit; start, 8 data, parity slot, stop.
// Notes:   Idles at mark, as the biased pair does.
`timescale 1ns/1ps
module isad_node #(
    parameter int BIT = 544
) (
    // Clock
    input  wire logic       pclk,
    // Line
    input  wire logic       line_txd,
    input  wire logic       line_drv_en,
    output logic            line_rxd,
    // Last character seen, parity slot on top
    output logic [8:0]      got
);
    int i;

    // Sample mid-bit after each start edge while the driver is on
    initial
    begin
        line_rxd = 1'b1;
        got      = 9'h000;
        forever
        begin
            // Enable and data change in one step; look one clock on
            @(negedge line_txd);
            @(posedge pclk);
            if (line_drv_en === 1'b1)
            begin
                repeat (BIT / 2 - 1) @(posedge pclk);
                for (i = 0; i < 9; i++)
                begin
                    repeat (BIT) @(posedge pclk);
                    got[i] <= line_txd;
                end
            end
        end
    end

    // Send one frame; waits for the driver to turn off before starting
    task automatic send(input logic [8:0] ch);
        logic [10:0] f;
        int          k;
        f = {1'b1, ch, 1'b0};
        while (line_drv_en === 1'b1) @(posedge pclk);
        for (k = 0; k < 11; k++)
        begin
            @(posedge pclk);
            line_rxd <= f[k];
            repeat (BIT - 1) @(posedge pclk);
        end
    endtask
endmodule

// ===== test_isolated_serial_auto_direction.sv
// Purpose: Self-checking bench for the auto-direction serial port.
// Assumes: DIV 1 with high range, so one tick is 34 clocks.
// Notes:   Spans allow 80 clocks of phase slack each end.
`timescale 1ns/1ps
`include "isad_regs.svh"
`define CHK(n, e, g) \
    begin \
        checked++; \
        if ((g) !== (e)) \
        begin \
            fail_count++; \
            $display("CHECK FAILED %s exp %0h got %0h", n, e, g); \
        end \
    end
module test_isolated_serial_auto_direction;
    import isad_pkg::*;
    localparam int TCK = 34;
    localparam int BIT = 16 * TCK;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        line_txd;
    logic        line_drv_en;
    logic        line_rxd;
    logic        line_rx_en;
    isad_line_t  line_mode;
    logic [8:0]  got;
    logic [31:0] rd;
    logic        er;
    int          fail_count = 0;
    int          checked = 0;

    // 250 MHz clock
    always #2 pclk = ~pclk;

    isad_uart dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .line_txd(line_txd),
        .line_drv_en(line_drv_en), .line_rxd(line_rxd),
        .line_rx_en(line_rx_en), .line_mode(line_mode));

    isad_node #(.BIT(BIT)) node (.pclk(pclk), .line_txd(line_txd),
        .line_drv_en(line_drv_en), .line_rxd(line_rxd), .got(got));

    // One APB transfer; only the watchdog ends a stuck wait
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Reset values and an unmapped address
    task automatic t_reset;
        apb(1'b0, `ISAD_OFF_CTRL, 32'h0);
        `CHK("ctrl", 32'h083, rd)
        apb(1'b0, `ISAD_OFF_DIV, 32'h0);
        `CHK("div", 32'h1, rd)
        apb(1'b1, `ISAD_OFF_DIV, 32'h2);
        apb(1'b0, `ISAD_OFF_DIV, 32'h0);
        `CHK("div wr", 32'h2, rd)
        // Back to one so the tick stays 34 clocks
        apb(1'b1, `ISAD_OFF_DIV, 32'h1);
        apb(1'b0, `ISAD_OFF_STAT, 32'h0);
        `CHK("stat", 32'h21, rd)
        apb(1'b0, 8'h10, 32'h0);
        `CHK("unmapped", 1'b1, er)
        `CHK("drv idle", 1'b0, line_drv_en)
        $display("test reset done");
    endtask

    // Every line configuration
    task automatic t_mode;
        logic [8:0] c [3] = '{9'h080, 9'h180, 9'h100};
        isad_line_t m [3] = '{LINE_TWO_WIRE, LINE_FOUR_WIRE, LINE_P2P};
        for (int i = 0; i < 3; i++)
        begin
            apb(1'b1, `ISAD_OFF_CTRL, {23'h0, c[i]});
            // Register lands at the access edge; look one later
            @(posedge pclk);
            `CHK("mode", m[i], line_mode)
        end
        // Driver enable follows the mode one clock later
        @(posedge pclk);
        `CHK("p2p drv", 1'b1, line_drv_en)
        $display("test mode done");
    endtask

    // One character: driver span is char plus equal hold
    task automatic t_tx(input logic [8:0] c, input logic [7:0] d,
                        input logic [8:0] e, input logic [8:0] mk,
                        input int tk);
        int   n;
        int   lo;
        logic both;
        apb(1'b1, `ISAD_OFF_CTRL, {23'h0, c});
        apb(1'b1, `ISAD_OFF_DATA, {24'h0, d});
        n = 0;
        both = 1'b0;
        while (line_drv_en !== 1'b1 && n < 10)
        begin
            @(posedge pclk);
            n++;
        end
        `CHK("drv on", 1'b1, line_drv_en)
        n = 0;
        while (line_drv_en === 1'b1 && n < 40000)
        begin
            @(posedge pclk);
            n++;
            // Only cycles that still drive; the exit cycle is idle
            both |= line_rx_en & line_drv_en;
        end
        lo = 2 * tk * TCK;
        `CHK("span", 1'b1, n > lo - 80 && n < lo + 80)
        `CHK("rx gated", 1'b0, both)
        @(posedge pclk);
        `CHK("rx back", 1'b1, line_rx_en)
        `CHK("char", e, got & mk)
        $display("test tx done");
    endtask

    // Receive with bad parity, flag then write-one-clear
    task automatic t_rx;
        node.send({1'b1, 8'h3c});
        repeat (2 * BIT) @(posedge pclk);
        apb(1'b0, `ISAD_OFF_STAT, 32'h0);
        `CHK("rx avail", 2'b11, {rd[6], rd[2]})
        apb(1'b0, `ISAD_OFF_DATA, 32'h0);
        `CHK("rx data", 32'h3c, rd)
        apb(1'b1, `ISAD_OFF_STAT, 32'h40);
        apb(1'b0, `ISAD_OFF_STAT, 32'h0);
        `CHK("perr clr", 1'b0, rd[6])
        $display("test rx done");
    endtask

    // Fill the send queue, then empty it with a mid-run reset
    task automatic t_fill;
        for (int i = 0; i < 17; i++)
            apb(1'b1, `ISAD_OFF_DATA, i);
        apb(1'b0, `ISAD_OFF_STAT, 32'h0);
        `CHK("tx full", 1'b1, rd[1])
        presetn <= 1'b0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `ISAD_OFF_STAT, 32'h0);
        `CHK("tx empty", 32'h21, rd)
        $display("test fill done");
    endtask

    task automatic close_out;
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Main sequence; 8E1, 5N2 and 7O1.5 frames
    initial
    begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        t_reset;
        t_mode;
        t_tx(9'h0d3, 8'ha5, 9'h0a5, 9'h1ff, 176);
        t_tx(9'h0c8, 8'h15, 9'h015, 9'h01f, 128);
        t_tx(9'h0e6, 8'h5a, 9'h0da, 9'h0ff, 168);
        t_rx;
        t_fill;
        close_out;
    end

    // Hang guard, well past the expected run
    initial
    begin
        repeat (100000) @(posedge pclk);
        fail_count++;
        close_out;
    end
endmodule
